// ===== rtl/xlk_map.svh
// Timing counts and constant values for the exclusive lock forwarding block
`ifndef XLK_MAP_SVH
`define XLK_MAP_SVH
`define XLK_CLK_PERIOD_NS   50
`define XLK_ADDR_W          32
`define XLK_CMD_W           4
`define XLK_BE_W            4
`define XLK_LOCK_IDLE       1'b1
`define XLK_CMD_MEM_RD      4'h6
`endif

// ===== rtl/xlk_pkg.sv
// Types shared by both ends of the exclusive lock forwarding block
`include "xlk_map.svh"
package xlk_pkg;
  typedef enum logic [1:0] {XLK_TERM_OK, XLK_TERM_RETRY, XLK_TERM_TABORT, XLK_TERM_MABORT} xlk_term_t;
  typedef enum logic [2:0] {XLK_IDLE, XLK_QUEUED, XLK_WAIT_BUS, XLK_SEC_ISSUED, XLK_SEC_HELD,
                            XLK_ESTABLISHED, XLK_ABORTED, XLK_RELEASE} xlk_state_t;
  typedef struct packed {
    logic [`XLK_ADDR_W-1:0] addr;
    logic [`XLK_CMD_W-1:0]  cmd;
    logic [`XLK_BE_W-1:0]   be;
    logic                   par;
  } xlk_req_t;
endpackage

// ===== rtl/xlk_if.sv
// Interface joining the bridge lock logic and the primary lock initiator
`timescale 1ns/100ps
interface xlk_if;
  logic               p_frame_n;
  logic               p_lock_n;
  logic               p_addr_phase;
  logic               p_cross;
  logic               p_is_write;
  logic               p_data_done;
  xlk_pkg::xlk_req_t  p_req;
  logic               resp_valid;
  xlk_pkg::xlk_term_t resp_term;
  modport bridge (input p_frame_n, p_lock_n, p_addr_phase, p_cross, p_is_write, p_data_done, p_req,
                  output resp_valid, resp_term);
  modport initiator (output p_frame_n, p_lock_n, p_addr_phase, p_cross, p_is_write, p_data_done, p_req,
                     input resp_valid, resp_term);
endinterface

// ===== rtl/xlk_bridge.sv
// Bridge end: downstream lock acquisition, queue blocking and lock release
`timescale 1ns/100ps
module xlk_bridge (
  input  wire logic               core_clk,
  input  wire logic               srst,
  xlk_if.bridge                   pb,
  input  wire logic               q_older_empty,
  output      logic               q_locked_push,
  output      logic               q_block,
  output      logic               q_no_prefetch,
  output      logic               q_post_write,
  output      logic               up_lock_fwd,
  input  wire logic               s_frame_n_in,
  input  wire logic               s_irdy_n_in,
  input  wire logic               s_lock_n_in,
  output      logic               s_lock_n_out,
  output      logic               s_lock_oe,
  output      logic               s_req,
  input  wire logic               s_addr_phase,
  input  wire logic               s_data_done,
  input  wire logic               s_end,
  input  wire xlk_pkg::xlk_term_t s_term,
  input  wire logic               s_posted,
  input  wire logic               m_timeout,
  input  wire logic               serr_en,
  input  wire logic               mabort_mode,
  output      logic               p_serr_n,
  output      logic               sig_serr,
  output      logic               rcv_tabort,
  output      logic               rcv_mabort
);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    xlk_pkg::xlk_state_t st;
    xlk_pkg::xlk_req_t   req;
    logic                abort_ma;
    logic                last_posted;
    logic                lock_n;
    logic                lock_oe;
    logic                req_bus;
    logic                push;
    logic                resp_valid;
    xlk_pkg::xlk_term_t  resp_term;
    logic                serr_n;
    logic                sig_serr;
    logic                rtab;
    logic                rmab;
    logic                addr_seen;
    logic                blk;
  } xlk_bst_t;

  xlk_bst_t s_r;
  xlk_bst_t s_nxt;
  logic     lock_start;
  logic     match;
  logic     sec_idle;
  logic     serr_evt;

  // A locked request is an address phase with lock high, then lock low a clock later
  assign lock_start = s_r.addr_seen & ~pb.p_lock_n;
  assign match      = (pb.p_req.addr == s_r.req.addr) && (pb.p_req.cmd == s_r.req.cmd) && (pb.p_req.be == s_r.req.be);
  assign sec_idle   = s_frame_n_in & s_irdy_n_in;

  always_comb begin
    s_nxt            = s_r;
    s_nxt.push       = 1'b0;
    s_nxt.resp_valid = 1'b0;
    s_nxt.resp_term  = xlk_pkg::XLK_TERM_RETRY;
    serr_evt         = 1'b0;
    s_nxt.addr_seen  = pb.p_addr_phase & pb.p_cross & pb.p_lock_n;
    case (s_r.st)
      xlk_pkg::XLK_IDLE: begin
        // Only primary-side locks cross; a secondary lock leaves this alone
        if (lock_start && !pb.p_is_write) begin
          s_nxt.req        = pb.p_req;
          s_nxt.last_posted = 1'b0;
          s_nxt.push       = 1'b1;
          s_nxt.resp_valid = 1'b1;
          s_nxt.st         = xlk_pkg::XLK_QUEUED;
        end
      end
      xlk_pkg::XLK_QUEUED: begin
        // Older queued work drains first
        if (q_older_empty) begin
          s_nxt.st = xlk_pkg::XLK_WAIT_BUS;
        end
      end
      xlk_pkg::XLK_WAIT_BUS: begin
        // Foreign lock must be seen free on an idle bus
        if (sec_idle && s_lock_n_in) begin
          s_nxt.req_bus = 1'b1;
        end
        if (s_r.req_bus && s_addr_phase) begin
          s_nxt.req_bus = 1'b0;
          s_nxt.lock_oe = 1'b1;
          s_nxt.lock_n  = `XLK_LOCK_IDLE;
          s_nxt.st      = xlk_pkg::XLK_SEC_ISSUED;
        end
      end
      xlk_pkg::XLK_SEC_ISSUED: begin
        s_nxt.lock_n = 1'b0;
        if (s_data_done) begin
          s_nxt.st = xlk_pkg::XLK_SEC_HELD;
        end else if (s_end && s_term == xlk_pkg::XLK_TERM_RETRY) begin
          // First transaction retried: give the lock up and try again
          s_nxt.lock_n  = `XLK_LOCK_IDLE;
          s_nxt.lock_oe = 1'b0;
          s_nxt.st      = xlk_pkg::XLK_WAIT_BUS;
        end else if (s_end && (s_term == xlk_pkg::XLK_TERM_TABORT || s_term == xlk_pkg::XLK_TERM_MABORT)) begin
          s_nxt.abort_ma = (s_term == xlk_pkg::XLK_TERM_MABORT);
          s_nxt.lock_n   = `XLK_LOCK_IDLE;
          s_nxt.lock_oe  = 1'b0;
          s_nxt.st       = xlk_pkg::XLK_ABORTED;
        end
      end
      xlk_pkg::XLK_SEC_HELD: begin
        if (m_timeout) begin
          serr_evt      = 1'b1;
          s_nxt.lock_n  = `XLK_LOCK_IDLE;
          s_nxt.lock_oe = 1'b0;
          s_nxt.st      = xlk_pkg::XLK_IDLE;
        end else if (lock_start && match) begin
          // Repeat without the lock sequence is not recognised
          s_nxt.resp_valid = 1'b1;
          s_nxt.resp_term  = xlk_pkg::XLK_TERM_OK;
          s_nxt.st         = xlk_pkg::XLK_ESTABLISHED;
        end else if (lock_start) begin
          s_nxt.resp_valid = 1'b1;
        end
      end
      xlk_pkg::XLK_ESTABLISHED: begin
        // Secondary lock held across the sequence; retries do not touch it
        // Later transactions keep lock asserted through their address phase
        if (pb.p_addr_phase && pb.p_cross) begin
          s_nxt.last_posted = pb.p_is_write;
        end
        if (pb.p_lock_n && pb.p_frame_n) begin
          // Posted last ends with its own write, delayed last once primary is idle
          s_nxt.st = (s_r.last_posted && !s_end) ? xlk_pkg::XLK_RELEASE : xlk_pkg::XLK_IDLE;
          if (!(s_r.last_posted && !s_end)) begin
            s_nxt.lock_n  = `XLK_LOCK_IDLE;
            s_nxt.lock_oe = 1'b0;
          end
        end
      end
      xlk_pkg::XLK_RELEASE: begin
        if (s_end) begin
          s_nxt.lock_n  = `XLK_LOCK_IDLE;
          s_nxt.lock_oe = 1'b0;
          s_nxt.st      = xlk_pkg::XLK_IDLE;
        end
      end
      xlk_pkg::XLK_ABORTED: begin
        if (lock_start && match) begin
          s_nxt.resp_valid = 1'b1;
          s_nxt.resp_term  = xlk_pkg::XLK_TERM_TABORT;
          s_nxt.rtab       = ~s_r.abort_ma;
          s_nxt.rmab       = s_r.abort_ma;
          s_nxt.st         = xlk_pkg::XLK_IDLE;
        end
      end
      default: begin
        s_nxt.st = xlk_pkg::XLK_IDLE;
      end
    endcase
    // Unanswered attempts outside idle are retried; a locked write seen in idle is left unanswered
    if (lock_start && !s_nxt.resp_valid && s_r.st != xlk_pkg::XLK_IDLE) begin
      s_nxt.resp_valid = 1'b1;
    end
    // A posted last write cannot report back, so its target abort, or master abort with mabort_mode set, goes to system error
    if (s_r.st == xlk_pkg::XLK_ESTABLISHED || s_r.st == xlk_pkg::XLK_RELEASE) begin
      if (s_r.last_posted && s_end && s_posted) begin
        if (s_term == xlk_pkg::XLK_TERM_TABORT || (s_term == xlk_pkg::XLK_TERM_MABORT && mabort_mode)) begin
          serr_evt = 1'b1;
        end
      end
    end
    s_nxt.blk = (s_nxt.st != xlk_pkg::XLK_IDLE);
    // System error only when enabled, and flagged only when enabled
    s_nxt.serr_n = ~(serr_evt & serr_en);
    if (serr_evt && serr_en) begin
      s_nxt.sig_serr = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_r        <= '0;
      s_r.st     <= xlk_pkg::XLK_IDLE;
      s_r.lock_n <= `XLK_LOCK_IDLE;
      s_r.serr_n <= 1'b1;
      s_r.resp_term <= xlk_pkg::XLK_TERM_RETRY;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign pb.resp_valid  = s_r.resp_valid;
  assign pb.resp_term   = s_r.resp_term;
  assign q_locked_push  = s_r.push;
  assign q_block        = s_r.blk;
  assign q_no_prefetch  = s_r.blk;
  assign q_post_write   = 1'b1;
  assign up_lock_fwd    = 1'b0;
  assign s_lock_n_out   = s_r.lock_n;
  assign s_lock_oe      = s_r.lock_oe;
  assign s_req          = s_r.req_bus;
  assign p_serr_n       = s_r.serr_n;
  assign sig_serr       = s_r.sig_serr;
  assign rcv_tabort     = s_r.rtab;
  assign rcv_mabort     = s_r.rmab;

endmodule

// ===== rtl/xlk_initiator.sv
// Primary initiator end: runs a locked sequence through the bridge
`timescale 1ns/100ps
module xlk_initiator (
  input  wire logic               core_clk,
  input  wire logic               srst,
  xlk_if.initiator                pb,
  input  wire logic               start,
  input  wire logic               bus_idle,
  input  wire logic               lock_seen_n,
  input  wire xlk_pkg::xlk_req_t  req,
  input  wire logic               is_write,
  input  wire logic               finish,
  output      logic               busy,
  output      logic               locked,
  output      logic               aborted
);

  typedef enum {XI_IDLE, XI_ADDR, XI_DATA, XI_HOLD, XI_REL} xlk_ist_t;
  typedef struct packed {
    xlk_ist_t          st;
    logic              frame_n;
    logic              lock_n;
    logic              addr;
    logic              wr;
    logic              done;
    xlk_pkg::xlk_req_t rq;
    logic              locked;
    logic              aborted;
  } xlk_is_t;

  xlk_is_t s_r;
  xlk_is_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.addr = 1'b0;
    s_nxt.done = 1'b0;
    case (s_r.st)
      XI_IDLE: begin
        // Idle bus and free lock before starting
        if ((start || (s_r.rq != '0 && !s_r.locked && !s_r.aborted)) && bus_idle && lock_seen_n) begin
          if (start) begin
            s_nxt.rq = req;
            s_nxt.wr      = 1'b0;
            s_nxt.aborted = 1'b0;
          end
          s_nxt.frame_n = 1'b0;
          s_nxt.lock_n  = 1'b1;
          s_nxt.addr    = 1'b1;
          s_nxt.st      = XI_ADDR;
        end
      end
      XI_ADDR: begin
        s_nxt.lock_n = 1'b0;
        s_nxt.st     = XI_DATA;
      end
      XI_DATA: begin
        if (pb.resp_valid) begin
          s_nxt.frame_n = 1'b1;
          if (pb.resp_term == xlk_pkg::XLK_TERM_OK) begin
            s_nxt.done   = 1'b1;
            s_nxt.locked = 1'b1;
            s_nxt.st     = XI_HOLD;
          end else if (pb.resp_term == xlk_pkg::XLK_TERM_TABORT) begin
            s_nxt.aborted = 1'b1;
            s_nxt.st      = XI_REL;
          end else begin
            s_nxt.lock_n = 1'b1;
            s_nxt.st     = XI_IDLE;
          end
        end
      end
      XI_HOLD: begin
        s_nxt.frame_n = 1'b1;
        if (finish) begin
          s_nxt.st = XI_REL;
        end else if (start) begin
          // A later locked transaction keeps lock asserted and runs one data phase
          s_nxt.frame_n = 1'b0;
          s_nxt.addr    = 1'b1;
          s_nxt.wr      = is_write;
        end
      end
      XI_REL: begin
        s_nxt.lock_n = 1'b1;
        s_nxt.locked = 1'b0;
        s_nxt.rq     = '0;
        s_nxt.st     = XI_IDLE;
      end
      default: begin
        s_nxt.st = XI_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_r         <= '0;
      s_r.st      <= XI_IDLE;
      s_r.frame_n <= 1'b1;
      s_r.lock_n  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pb.p_frame_n    = s_r.frame_n;
  assign pb.p_lock_n     = s_r.lock_n;
  assign pb.p_addr_phase = s_r.addr;
  assign pb.p_cross      = 1'b1;
  assign pb.p_is_write   = s_r.wr;
  assign pb.p_data_done  = s_r.done;
  assign pb.p_req        = s_r.rq;
  assign busy            = (s_r.st != XI_IDLE);
  assign locked          = s_r.locked;
  assign aborted         = s_r.aborted;

endmodule

// ===== testbench/xlk_monitor.sv
// Checker on the primary lock interface between the two ends
`timescale 1ns/100ps
module xlk_monitor (
  input wire logic               core_clk,
  input wire logic               srst,
  input wire logic               p_frame_n,
  input wire logic               p_lock_n,
  input wire logic               p_addr_phase,
  input wire logic               p_cross,
  input wire logic               p_is_write,
  input wire logic               p_data_done,
  input wire xlk_pkg::xlk_req_t  p_req,
  input wire logic               resp_valid,
  input wire xlk_pkg::xlk_term_t resp_term
);
  // ****************************************
  // Lock tracking seen from the wire
  // ****************************************
  logic              pend_r;
  logic              lockd_r;
  xlk_pkg::xlk_req_t last_r;
  xlk_pkg::xlk_req_t req_r;
  logic              addr_r;
  logic              take;
  logic              t_ok;
  // A locked attempt is an address phase with lock free, then lock taken a clock later
  assign take = addr_r && !p_lock_n;
  assign t_ok = resp_valid && resp_term == xlk_pkg::XLK_TERM_OK;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      addr_r  <= 1'b0;
      pend_r  <= 1'b0;
      lockd_r <= 1'b0;
      last_r  <= '0;
      req_r   <= '0;
    end else begin
      addr_r <= p_addr_phase && p_cross && p_lock_n;
      if (p_addr_phase) begin
        last_r <= p_req;
      end
      if (resp_valid && resp_term == xlk_pkg::XLK_TERM_RETRY && !pend_r && !lockd_r) begin
        pend_r <= 1'b1;
        req_r  <= last_r;
      end else if (resp_valid && pend_r && resp_term != xlk_pkg::XLK_TERM_RETRY) begin
        pend_r  <= 1'b0;
        lockd_r <= t_ok;
      end else if (lockd_r && p_lock_n && p_frame_n) begin
        lockd_r <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_resp_cause;
    resp_valid |-> $past(take);
  endproperty
  property p_first_retry;
    take && !p_is_write && !pend_r && !lockd_r |=> resp_valid && resp_term == xlk_pkg::XLK_TERM_RETRY;
  endproperty
  property p_ok_pending;
    t_ok |-> pend_r || lockd_r;
  endproperty
  property p_ok_match;
    t_ok && pend_r |-> last_r.addr == req_r.addr && last_r.cmd == req_r.cmd && last_r.be == req_r.be;
  endproperty
  property p_abort_pending;
    resp_valid && resp_term inside {xlk_pkg::XLK_TERM_TABORT, xlk_pkg::XLK_TERM_MABORT} |-> pend_r;
  endproperty
  property p_other_retry;
    take && pend_r && p_req.addr != req_r.addr |=> resp_valid && resp_term == xlk_pkg::XLK_TERM_RETRY;
  endproperty
  property p_reset_quiet;
    disable iff (1'b0) srst |=> !resp_valid;
  endproperty
  property p_resp_stands;
    resp_valid && !take |=> !resp_valid;
  endproperty
  a_resp_cause: assert property (p_resp_cause) else $error("response without a request");
  a_first_retry: assert property (p_first_retry) else $error("first locked read not retried");
  a_ok_pending: assert property (p_ok_pending) else $error("data returned with no pending read");
  a_ok_match: assert property (p_ok_match) else $error("data returned to other request");
  a_abort_pending: assert property (p_abort_pending) else $error("abort with no pending read");
  a_other_retry: assert property (p_other_retry) else $error("other request not retried");
  a_reset_quiet: assert property (p_reset_quiet) else $error("response during reset");
  a_resp_stands: assert property (p_resp_stands) else $error("response longer than one cycle");
  cover property (t_ok);
  cover property (resp_valid && resp_term == xlk_pkg::XLK_TERM_TABORT);
  cover property (resp_valid && resp_term == xlk_pkg::XLK_TERM_RETRY);
endmodule

// ===== testbench/bridge_exclusive_lock_forwarding_tb.sv
// Testbench joining both lock ends and driving their user sides
`timescale 1ns/100ps
`include "xlk_map.svh"
module bridge_exclusive_lock_forwarding_tb;
  logic core_clk, srst, q_older_empty, s_frame_n_in, s_irdy_n_in, s_lock_n_in, s_addr_phase, s_data_done;
  logic s_end, s_posted, m_timeout, serr_en, mabort_mode, start, bus_idle, lock_seen_n, is_write, finish;
  logic q_locked_push, q_block, q_no_prefetch, q_post_write, up_lock_fwd, s_lock_n_out, s_lock_oe, s_req;
  logic p_serr_n, sig_serr, rcv_tabort, rcv_mabort, busy, locked, aborted;
  xlk_pkg::xlk_term_t s_term;
  xlk_pkg::xlk_req_t  req;
  int                 fail_count;
  int                 compares;
  int                 n;
  xlk_if pb ();
  xlk_bridge u_xlk_bridge (.core_clk, .srst, .pb(pb.bridge), .q_older_empty, .q_locked_push, .q_block,
    .q_no_prefetch, .q_post_write, .up_lock_fwd, .s_frame_n_in, .s_irdy_n_in, .s_lock_n_in, .s_lock_n_out,
    .s_lock_oe, .s_req, .s_addr_phase, .s_data_done, .s_end, .s_term, .s_posted, .m_timeout, .serr_en,
    .mabort_mode, .p_serr_n, .sig_serr, .rcv_tabort, .rcv_mabort);
  xlk_initiator u_xlk_initiator (.core_clk, .srst, .pb(pb.initiator), .start, .bus_idle, .lock_seen_n,
    .req, .is_write, .finish, .busy, .locked, .aborted);
  xlk_monitor u_xlk_monitor (.core_clk, .srst, .p_frame_n(pb.p_frame_n), .p_lock_n(pb.p_lock_n),
    .p_addr_phase(pb.p_addr_phase), .p_cross(pb.p_cross), .p_is_write(pb.p_is_write),
    .p_data_done(pb.p_data_done), .p_req(pb.p_req), .resp_valid(pb.resp_valid), .resp_term(pb.resp_term));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  // Repeats of the read may be retried first, so wait for the wanted code
  task automatic wait_resp(input xlk_pkg::xlk_term_t term);
    for (n = 0; n < 60 && !(pb.resp_valid === 1'b1 && pb.resp_term === term); n++) cyc(1);
    chk({pb.resp_valid, pb.resp_term}, {1'b1, term});
  endtask
  task automatic sec_issue();
    req = '{addr: 32'h0000_1000, cmd: `XLK_CMD_MEM_RD, be: 4'hf, par: 1'b1};
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    wait_resp(xlk_pkg::XLK_TERM_RETRY);
    chk(q_locked_push, 1'b1);
    cyc(1);
    chk({q_block, q_no_prefetch, s_req}, 3'b110);
    s_lock_n_in = 1'b0;
    s_frame_n_in = 1'b0;
    q_older_empty = 1'b1;
    cyc(4);
    chk(s_req, 1'b0);
    s_lock_n_in = 1'b1;
    s_frame_n_in = 1'b1;
    for (n = 0; n < 20 && s_req !== 1'b1; n++) cyc(1);
    chk(s_req, 1'b1);
    q_older_empty = 1'b0;
    s_addr_phase = 1'b1;
    cyc(1);
    s_addr_phase = 1'b0;
    chk({s_lock_oe, s_lock_n_out}, 2'b11);
    cyc(1);
    chk({s_lock_oe, s_lock_n_out}, 2'b10);
  endtask
  task automatic t_idle();
    chk({s_lock_n_out, s_lock_oe, p_serr_n, sig_serr, rcv_tabort, rcv_mabort, q_block, s_req}, 8'ha0);
    chk({q_post_write, up_lock_fwd}, 2'b10);
  endtask
  // With post set, a locked write ends the sequence and its secondary end releases the lock
  task automatic t_acquire(input logic post);
    sec_issue();
    s_data_done = 1'b1;
    s_end = 1'b1;
    s_term = xlk_pkg::XLK_TERM_OK;
    cyc(1);
    s_data_done = 1'b0;
    s_end = 1'b0;
    wait_resp(xlk_pkg::XLK_TERM_OK);
    for (n = 0; n < 20 && locked !== 1'b1; n++) cyc(1);
    chk({locked, busy, s_lock_n_out, s_lock_oe}, 4'b1101);
    if (post) begin
      is_write = 1'b1;
      start = 1'b1;
      cyc(1);
      start = 1'b0;
      is_write = 1'b0;
    end
    finish = 1'b1;
    cyc(1);
    finish = 1'b0;
    if (post) begin
      serr_en = 1'b1;
      mabort_mode = 1'b1;
      cyc(3);
      chk({s_lock_n_out, s_lock_oe, q_block}, 3'b011);
      s_end = 1'b1;
      s_posted = 1'b1;
      s_term = xlk_pkg::XLK_TERM_MABORT;
      cyc(1);
      s_end = 1'b0;
      s_posted = 1'b0;
      chk({p_serr_n, sig_serr}, 2'b01);
    end
    for (n = 0; n < 20 && s_lock_n_out !== 1'b1; n++) cyc(1);
    chk({s_lock_n_out, q_block}, 2'b10);
  endtask
  task automatic t_abort(input xlk_pkg::xlk_term_t term);
    sec_issue();
    s_end = 1'b1;
    s_term = term;
    cyc(1);
    s_end = 1'b0;
    wait_resp(xlk_pkg::XLK_TERM_TABORT);
    cyc(2);
    chk({rcv_tabort, rcv_mabort}, {term == xlk_pkg::XLK_TERM_TABORT, term == xlk_pkg::XLK_TERM_MABORT});
    chk({aborted, s_lock_n_out, q_block, locked}, 4'b1100);
    finish = 1'b1;
    cyc(1);
    finish = 1'b0;
  endtask
  // Time-out lands right after the secondary lock is held, before the repeat can collect
  task automatic t_timeout();
    serr_en = 1'b1;
    sec_issue();
    s_data_done = 1'b1;
    cyc(1);
    s_data_done = 1'b0;
    m_timeout = 1'b1;
    cyc(1);
    m_timeout = 1'b0;
    for (n = 0; n < 5 && p_serr_n !== 1'b0; n++) cyc(1);
    chk(p_serr_n, 1'b0);
    cyc(2);
    chk({sig_serr, s_lock_n_out, p_serr_n}, 3'b111);
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    cyc(1);
    t_idle();
  endtask
  // ****************************************
  // Clock, reset, sequence and watchdog
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    {q_older_empty, s_addr_phase, s_data_done, s_end, s_posted, m_timeout, serr_en} = '0;
    {mabort_mode, start, is_write, finish} = '0;
    {s_frame_n_in, s_irdy_n_in, s_lock_n_in, bus_idle, lock_seen_n} = '1;
    s_term = xlk_pkg::XLK_TERM_OK;
    req = '0;
    fail_count = 0;
    compares = 0;
    srst = 1'b1;
    cyc(4);
    srst = 1'b0;
    cyc(1);
    t_idle();
    t_acquire(1'b0);
    t_abort(xlk_pkg::XLK_TERM_TABORT);
    t_timeout();
    t_acquire(1'b1);
    t_abort(xlk_pkg::XLK_TERM_MABORT);
    close_out();
  end
  initial begin
    #(`XLK_CLK_PERIOD_NS * 3000);
    fail_count++;
    close_out();
  end
endmodule
